// ===== include/fsap_defines.vh
// Constants for the serial flash status and array protection block.
// Assumes a single include per compile unit; the guard allows repeats.
`ifndef FSAP_DEFINES_VH
`define FSAP_DEFINES_VH

// Instruction codes.
`define FSAP_OP_WREN 8'h06
`define FSAP_OP_WRDI 8'h04
`define FSAP_OP_RDSR_LOW 8'h05
`define FSAP_OP_RDSR_HIGH 8'h35
`define FSAP_OP_WRSR 8'h01
`define FSAP_OP_PAGE_PROG 8'h02
`define FSAP_OP_QUAD_PROG 8'h32
`define FSAP_OP_SECTOR_ERASE 8'h20
`define FSAP_OP_BLOCK_ERASE 8'hD8
`define FSAP_OP_CHIP_ERASE 8'hC7
`define FSAP_OP_SEC_ERASE 8'h44
`define FSAP_OP_SEC_PROG 8'h42
`define FSAP_OP_SUSPEND 8'h75
`define FSAP_OP_RESUME 8'h7A

// Operation kinds handed to the program/erase engine.
`define FSAP_KIND_PAGE 3'h0
`define FSAP_KIND_QPAGE 3'h1
`define FSAP_KIND_SECTOR 3'h2
`define FSAP_KIND_BLOCK 3'h3
`define FSAP_KIND_CHIP 3'h4
`define FSAP_KIND_SEC_ERASE 3'h5
`define FSAP_KIND_SEC_PROG 3'h6

// Byte counts an instruction must reach before it may execute.
`define FSAP_BYTES_WRSR_ONE 3'h2
`define FSAP_BYTES_WRSR_TWO 3'h3
`define FSAP_BYTES_ADDR 3'h4
`define FSAP_BYTES_PROG 3'h5
`define FSAP_BYTES_OPCODE 3'h1
`define FSAP_BYTE_SAT 3'h7
`define FSAP_BIT_LAST 3'h7

// Field positions inside the low status byte.
`define FSAP_LOW_RANGE_HI 4
`define FSAP_LOW_RANGE_LO 2
`define FSAP_LOW_TB 5
`define FSAP_LOW_GRAN 6
`define FSAP_LOW_GUARD 7
// Field positions inside the high status byte.
`define FSAP_HIGH_LOCK 0
`define FSAP_HIGH_QUAD 1
`define FSAP_HIGH_LB_HI 5
`define FSAP_HIGH_LB_LO 2
`define FSAP_HIGH_INVERT 6

// Address fields: 4KB sector number and security page number.
`define FSAP_ADDR_SECT_HI 17
`define FSAP_ADDR_SECT_LO 12
`define FSAP_ADDR_BLOCK_HI 17
`define FSAP_ADDR_BLOCK_LO 16
`define FSAP_ADDR_SECPAGE_HI 13
`define FSAP_ADDR_SECPAGE_LO 12
`define FSAP_SECT_FIRST 6'h00
`define FSAP_SECT_LAST 6'h3F
`define FSAP_SUB_FIRST 4'h0
`define FSAP_SUB_LAST 4'hF

// Protected size in 4KB sectors.
`define FSAP_CNT_NONE 7'h00
`define FSAP_CNT_1 7'h01
`define FSAP_CNT_2 7'h02
`define FSAP_CNT_4 7'h04
`define FSAP_CNT_8 7'h08
`define FSAP_CNT_16 7'h10
`define FSAP_CNT_32 7'h20
`define FSAP_CNT_ALL 7'h40

// Status register write time in core clock cycles.
`define FSAP_SRW_CYCLES 8'h10
`define FSAP_SRW_LAST 8'h01

// Synchroniser reset value for {spiClk, csN, dataIn, guardN}.
`define FSAP_PIN_RESET 4'h5

`endif

// ===== verilog/fsap_sync.v
// Two-flop synchroniser for a group of independent pin levels.
// Assumes each bit is a level that is stable for several clocks.
`timescale 1ns/100ps
`default_nettype none
module fsap_sync #(
	parameter W = 1,
	parameter [W-1:0] RESET_VAL = {W{1'b0}}
) (
	// Clock and reset.
	input wire core_clk,
	input wire rst_n,
	// Levels.
	input wire [W-1:0] pinIn,
	output wire [W-1:0] pinSync
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	always @(posedge core_clk) begin
		if (!rst_n) begin
			meta_q <= RESET_VAL;
			sync_q <= RESET_VAL;
		end else begin
			meta_q <= pinIn;
			sync_q <= meta_q;
		end
	end

	assign pinSync = sync_q;
endmodule
`default_nettype wire

// ===== verilog/fsap_prot_range.v
// Decodes the protection fields into a sector range and checks a region.
// Assumes a 256KB array of sixty-four 4KB sectors.
`timescale 1ns/100ps
`default_nettype none
`include "fsap_defines.vh"
module fsap_prot_range (
	// Protection fields.
	input wire [2:0] rangeBits,
	input wire topBottomSelect,
	input wire granularitySelect,
	input wire invertProtect,
	// Region under test, in sectors.
	input wire [5:0] regFirst,
	input wire [5:0] regLast,
	output reg hit
);
	reg [6:0] cnt;
	reg [6:0] lo;
	reg [6:0] hi;
	reg empty;

	always @* begin
		cnt = `FSAP_CNT_NONE;
		if (!granularitySelect) begin
			case (rangeBits[1:0])
				2'h1: cnt = `FSAP_CNT_16;
				2'h2: cnt = `FSAP_CNT_32;
				2'h3: cnt = `FSAP_CNT_ALL;
				default: cnt = `FSAP_CNT_NONE;
			endcase
		end else begin
			case (rangeBits)
				3'h1: cnt = `FSAP_CNT_1;
				3'h2: cnt = `FSAP_CNT_2;
				3'h3: cnt = `FSAP_CNT_4;
				3'h4, 3'h5, 3'h6: cnt = `FSAP_CNT_8;
				3'h7: cnt = `FSAP_CNT_ALL;
				default: cnt = `FSAP_CNT_NONE;
			endcase
		end
		empty = (cnt == `FSAP_CNT_NONE);
		// A full count gives the whole array from either end.
		if (topBottomSelect) begin
			lo = `FSAP_CNT_NONE;
			hi = cnt - `FSAP_CNT_1;
		end else begin
			lo = `FSAP_CNT_ALL - cnt;
			hi = `FSAP_CNT_ALL - `FSAP_CNT_1;
		end
		if (invertProtect) begin
			hit = empty || ({1'b0, regFirst} < lo) || ({1'b0, regLast} > hi);
		end else begin
			hit = !empty && ({1'b0, regFirst} <= hi) && ({1'b0, regLast} >= lo);
		end
	end
endmodule
`default_nettype wire

// ===== verilog/fsap_status_core.v
// Status word, write gating and array protection of a small serial flash.
// Assumes SPI mode 0 or 3 pins from a host; rst_n is the power-on reset.
// Functional notes
// - Busy flag at bit 0 is set during program, erase and status writes.
// - While busy, only status reads and suspend are obeyed.
// - Busy clears when the running operation completes.
// - Write latch at bit 1 is set by write enable.
// - Write latch clears at power-up, write disable and any completed operation.
// - Three range bits at 4..2, written by status write, default nothing protected.
// - Top/bottom bit chooses which end of the array is protected.
// - Granularity bit picks 4KB sectors or 64KB blocks.
// - Invert bit at 14 swaps protected and unprotected portions.
// - Guard mode 0: write-guard pin ignored, status write needs write latch.
// - Guard mode 1: pin low refuses status writes, pin high allows them.
// - Write-guard pin acts only when four-lane mode is off.
// - Power cycle returns lockdown bit to 0.
// - Paused flag at 15 set by suspend, cleared by resume or power cycle.
// - Four security page locks at 13..10 are set-only and freeze their page.
// - Four-lane enable at 9 turns the guard pin into a data lane.
// - Reserved bits have no effect when written.
// - Block granularity codes protect none, 64KB, 128KB or all.
// - Sector granularity from top protects 4KB, 8KB, 16KB or 32KB.
// - Sector granularity from bottom protects the same sizes from zero.
// - Sector codes 000 protect nothing and 111 the whole array.
// - Program or erase touching a protected range is ignored.
`timescale 1ns/100ps
`default_nettype none
`include "fsap_defines.vh"
module fsap_status_core (
	// Clock and reset.
	input wire core_clk,
	input wire rst_n,
	// SPI pins from the host.
	input wire spiClk,
	input wire csN,
	input wire dataIn,
	input wire writeGuardN,
	output wire dataOut,
	output wire dataOutEn,
	// Program/erase engine.
	input wire engineDone,
	output wire opStart,
	output wire [2:0] opKind,
	output wire [23:0] opAddr,
	output wire suspendReq,
	output wire resumeReq,
	// Observed state.
	output wire [15:0] statusWord,
	output wire fourLaneEnable,
	output wire [3:0] securityPageLocks
);
	wire [3:0] pinSync;
	wire sclk;
	wire cs;
	wire din;
	wire guardN;
	reg sclkPrev_q;
	reg csPrev_q;
	wire riseE;
	wire fallE;
	wire csStart;
	wire csEnd;

	// SPI shifter state.
	reg [7:0] shiftIn_q;
	reg [2:0] bitCnt_q;
	reg [2:0] byteCnt_q;
	reg [7:0] opcode_q;
	reg [23:0] addr_q;
	reg [7:0] data1_q;
	reg [7:0] data2_q;
	reg [7:0] txByte_q;
	reg reading_q;
	reg readHigh_q;
	reg doOut_q;
	reg doOe_q;
	wire [7:0] rxByte;

	// Status fields.
	reg busy_q;
	reg busyArray_q;
	reg [7:0] srwCnt_q;
	reg wel_q;
	reg [2:0] range_q;
	reg tb_q;
	reg gran_q;
	reg guard_q;
	reg lock_q;
	reg quad_q;
	reg [3:0] secLocks_q;
	reg invert_q;
	reg paused_q;

	// Engine handshake.
	reg opStart_q;
	reg [2:0] opKind_q;
	reg [23:0] opAddr_q;
	reg suspendReq_q;
	reg resumeReq_q;

	wire [7:0] statusLow;
	wire [7:0] statusHigh;
	reg [5:0] regFirst;
	reg [5:0] regLast;
	wire protHit;
	wire wrsrAllowed;
	wire secPageLocked;
	wire [5:0] addrSect;
	wire [1:0] addrBlock;

	fsap_sync #(
		.W(4),
		.RESET_VAL(`FSAP_PIN_RESET)
	) u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.pinIn({spiClk, csN, dataIn, writeGuardN}),
		.pinSync(pinSync)
	);

	assign sclk = pinSync[3];
	assign cs = pinSync[2];
	assign din = pinSync[1];
	assign guardN = pinSync[0];

	// The serial clock is oversampled eight times, so edges are found by comparison.
	assign riseE = sclk && !sclkPrev_q && !cs;
	assign fallE = !sclk && sclkPrev_q && !cs;
	assign csStart = !cs && csPrev_q;
	assign csEnd = cs && !csPrev_q;
	assign rxByte = {shiftIn_q[6:0], din};

	assign statusLow = {guard_q, gran_q, tb_q, range_q, wel_q, busy_q};
	// Every high-byte position is a real field, but written bit 7 is thrown away since paused is set only by suspend.
	assign statusHigh = {paused_q, invert_q, secLocks_q, quad_q, lock_q};

	assign addrSect = addr_q[`FSAP_ADDR_SECT_HI:`FSAP_ADDR_SECT_LO];
	assign addrBlock = addr_q[`FSAP_ADDR_BLOCK_HI:`FSAP_ADDR_BLOCK_LO];

	always @* begin
		regFirst = addrSect;
		regLast = addrSect;
		case (opcode_q)
			`FSAP_OP_BLOCK_ERASE: begin
				regFirst = {addrBlock, `FSAP_SUB_FIRST};
				regLast = {addrBlock, `FSAP_SUB_LAST};
			end
			`FSAP_OP_CHIP_ERASE: begin
				regFirst = `FSAP_SECT_FIRST;
				regLast = `FSAP_SECT_LAST;
			end
			default: begin
				regFirst = addrSect;
				regLast = addrSect;
			end
		endcase
	end

	fsap_prot_range u_prot (
		.rangeBits(range_q),
		.topBottomSelect(tb_q),
		.granularitySelect(gran_q),
		.invertProtect(invert_q),
		.regFirst(regFirst),
		.regLast(regLast),
		.hit(protHit)
	);

	// In four-lane mode the guard pin carries data and must not gate writes.
	assign wrsrAllowed = wel_q && !lock_q && !(guard_q && !guardN && !quad_q);
	assign secPageLocked =
		secLocks_q[addr_q[`FSAP_ADDR_SECPAGE_HI:`FSAP_ADDR_SECPAGE_LO]];

	// Serial shifter and status read-out.
	always @(posedge core_clk) begin
		if (!rst_n) begin
			sclkPrev_q <= 1'b0;
			csPrev_q <= 1'b1;
			shiftIn_q <= 8'h00;
			bitCnt_q <= 3'h0;
			byteCnt_q <= 3'h0;
			opcode_q <= 8'h00;
			addr_q <= 24'h000000;
			data1_q <= 8'h00;
			data2_q <= 8'h00;
			txByte_q <= 8'h00;
			reading_q <= 1'b0;
			readHigh_q <= 1'b0;
			doOut_q <= 1'b0;
			doOe_q <= 1'b0;
		end else begin
			sclkPrev_q <= sclk;
			csPrev_q <= cs;
			doOe_q <= reading_q && !cs;
			if (csStart || csEnd) begin
				bitCnt_q <= 3'h0;
				reading_q <= 1'b0;
				if (csStart) begin
					byteCnt_q <= 3'h0;
				end
			end else if (riseE) begin
				shiftIn_q <= rxByte;
				bitCnt_q <= bitCnt_q + 3'h1;
				if (bitCnt_q == `FSAP_BIT_LAST) begin
					if (byteCnt_q != `FSAP_BYTE_SAT) begin
						byteCnt_q <= byteCnt_q + 3'h1;
					end
					if (byteCnt_q == 3'h0) begin
						opcode_q <= rxByte;
						if (rxByte == `FSAP_OP_RDSR_LOW || rxByte == `FSAP_OP_RDSR_HIGH) begin
							reading_q <= 1'b1;
							readHigh_q <= (rxByte == `FSAP_OP_RDSR_HIGH);
							txByte_q <= (rxByte == `FSAP_OP_RDSR_HIGH) ? statusHigh : statusLow;
						end
					end else begin
						if (byteCnt_q < `FSAP_BYTES_ADDR) begin
							addr_q <= {addr_q[15:0], rxByte};
						end
						if (byteCnt_q == `FSAP_BYTES_OPCODE) begin
							data1_q <= rxByte;
						end
						if (byteCnt_q == `FSAP_BYTES_WRSR_ONE) begin
							data2_q <= rxByte;
						end
						// Repeated reads always show the live status.
						if (reading_q) begin
							txByte_q <= readHigh_q ? statusHigh : statusLow;
						end
					end
				end
			end else if (fallE && reading_q) begin
				doOut_q <= txByte_q[7];
				txByte_q <= {txByte_q[6:0], 1'b0};
			end
		end
	end

	// Instruction execution at chip-select release and operation completion.
	always @(posedge core_clk) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
			busyArray_q <= 1'b0;
			srwCnt_q <= 8'h00;
			wel_q <= 1'b0;
			range_q <= 3'h0;
			tb_q <= 1'b0;
			gran_q <= 1'b0;
			guard_q <= 1'b0;
			lock_q <= 1'b0;
			quad_q <= 1'b0;
			secLocks_q <= 4'h0;
			invert_q <= 1'b0;
			paused_q <= 1'b0;
			opStart_q <= 1'b0;
			opKind_q <= `FSAP_KIND_PAGE;
			opAddr_q <= 24'h000000;
			suspendReq_q <= 1'b0;
			resumeReq_q <= 1'b0;
		end else begin
			opStart_q <= 1'b0;
			suspendReq_q <= 1'b0;
			resumeReq_q <= 1'b0;
			// Writes and erases must end on a byte boundary.
			if (csEnd && bitCnt_q == 3'h0 && byteCnt_q != 3'h0) begin
				if (busy_q) begin
					if (opcode_q == `FSAP_OP_SUSPEND && busyArray_q) begin
						paused_q <= 1'b1;
						busy_q <= 1'b0;
						suspendReq_q <= 1'b1;
					end
				end else begin
					case (opcode_q)
						`FSAP_OP_WREN: begin
							wel_q <= 1'b1;
						end
						`FSAP_OP_WRDI: begin
							wel_q <= 1'b0;
						end
						`FSAP_OP_RESUME: begin
							if (paused_q) begin
								paused_q <= 1'b0;
								busy_q <= 1'b1;
								busyArray_q <= 1'b1;
								resumeReq_q <= 1'b1;
							end
						end
						`FSAP_OP_WRSR: begin
							if (byteCnt_q >= `FSAP_BYTES_WRSR_ONE && wrsrAllowed) begin
								range_q <= data1_q[`FSAP_LOW_RANGE_HI:`FSAP_LOW_RANGE_LO];
								tb_q <= data1_q[`FSAP_LOW_TB];
								gran_q <= data1_q[`FSAP_LOW_GRAN];
								guard_q <= data1_q[`FSAP_LOW_GUARD];
								if (byteCnt_q >= `FSAP_BYTES_WRSR_TWO) begin
									lock_q <= data2_q[`FSAP_HIGH_LOCK];
									quad_q <= data2_q[`FSAP_HIGH_QUAD];
									secLocks_q <= secLocks_q |
										data2_q[`FSAP_HIGH_LB_HI:`FSAP_HIGH_LB_LO];
									invert_q <= data2_q[`FSAP_HIGH_INVERT];
								end
								busy_q <= 1'b1;
								busyArray_q <= 1'b0;
								srwCnt_q <= `FSAP_SRW_CYCLES;
							end
						end
						`FSAP_OP_PAGE_PROG, `FSAP_OP_QUAD_PROG, `FSAP_OP_SECTOR_ERASE,
						`FSAP_OP_BLOCK_ERASE: begin
							if (wel_q && !protHit && byteCnt_q >= ((opcode_q == `FSAP_OP_PAGE_PROG ||
								opcode_q == `FSAP_OP_QUAD_PROG) ? `FSAP_BYTES_PROG :
								`FSAP_BYTES_ADDR)) begin
								busy_q <= 1'b1;
								busyArray_q <= 1'b1;
								opStart_q <= 1'b1;
								opAddr_q <= addr_q;
								opKind_q <= (opcode_q == `FSAP_OP_PAGE_PROG) ? `FSAP_KIND_PAGE :
									(opcode_q == `FSAP_OP_QUAD_PROG) ? `FSAP_KIND_QPAGE :
									(opcode_q == `FSAP_OP_SECTOR_ERASE) ? `FSAP_KIND_SECTOR :
									`FSAP_KIND_BLOCK;
							end
						end
						`FSAP_OP_CHIP_ERASE: begin
							if (wel_q && !protHit) begin
								busy_q <= 1'b1;
								busyArray_q <= 1'b1;
								opStart_q <= 1'b1;
								opAddr_q <= 24'h000000;
								opKind_q <= `FSAP_KIND_CHIP;
							end
						end
						`FSAP_OP_SEC_ERASE, `FSAP_OP_SEC_PROG: begin
							if (wel_q && !secPageLocked && byteCnt_q >= `FSAP_BYTES_ADDR) begin
								busy_q <= 1'b1;
								busyArray_q <= 1'b1;
								opStart_q <= 1'b1;
								opAddr_q <= addr_q;
								opKind_q <= (opcode_q == `FSAP_OP_SEC_ERASE) ?
									`FSAP_KIND_SEC_ERASE : `FSAP_KIND_SEC_PROG;
							end
						end
						default: begin
							wel_q <= wel_q;
						end
					endcase
				end
			end
			// Completion of the running operation.
			if (busy_q && !busyArray_q) begin
				srwCnt_q <= srwCnt_q - 8'h01;
				if (srwCnt_q == `FSAP_SRW_LAST) begin
					busy_q <= 1'b0;
					wel_q <= 1'b0;
				end
			end else if (busy_q && engineDone) begin
				busy_q <= 1'b0;
				wel_q <= 1'b0;
			end
		end
	end

	assign dataOut = doOut_q;
	assign dataOutEn = doOe_q;
	assign opStart = opStart_q;
	assign opKind = opKind_q;
	assign opAddr = opAddr_q;
	assign suspendReq = suspendReq_q;
	assign resumeReq = resumeReq_q;
	assign statusWord = {statusHigh, statusLow};
	assign fourLaneEnable = quad_q;
	assign securityPageLocks = secLocks_q;
endmodule
`default_nettype wire

// ===== bench/fsap_checker.sv
// Checker for the flash status and protection block, bound to its top.
// Assumes one core clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module fsap_checker (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst_n,
	// Pins and engine handshake.
	input wire logic csN,
	input wire logic writeGuardN,
	input wire logic dataOutEn,
	input wire logic engineDone,
	input wire logic opStart,
	input wire logic suspendReq,
	input wire logic resumeReq,
	// Observed state.
	input wire logic [15:0] statusWord,
	input wire logic fourLaneEnable,
	input wire logic [3:0] securityPageLocks
);
	logic arrBusy_q;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// The engine only ends array work, so a status write busy is kept apart.
	always @(posedge core_clk) begin
		if (!rst_n)
			arrBusy_q <= 1'b0;
		else if (opStart || resumeReq)
			arrBusy_q <= 1'b1;
		else if (engineDone || suspendReq)
			arrBusy_q <= 1'b0;
	end
	busy_on_start_a: assert property (opStart |-> statusWord[0] && !$past(statusWord[0]))
		else $error("op started while busy or without busy");
	op_pulse_a: assert property (opStart |=> !opStart)
		else $error("op start longer than one cycle");
	done_clears_a: assert property (engineDone && arrBusy_q |=> statusWord[1:0] == 2'b00)
		else $error("busy or latch left after done");
	write_gate_a: assert property ($rose(statusWord[0]) && !opStart && !resumeReq
		|-> $past(statusWord[1]) && !$past(statusWord[8]))
		else $error("status write without latch or under lockdown");
	guard_gate_a: assert property ($rose(statusWord[0]) && !opStart && !resumeReq
		|-> !($past(statusWord[7]) && !$past(statusWord[9]) && !$past(writeGuardN, 3)))
		else $error("status write taken with guard pin low");
	lock_hold_a: assert property (statusWord[8] |=> statusWord[8])
		else $error("lockdown bit dropped");
	page_lock_sticky_a: assert property (($past(securityPageLocks) & ~securityPageLocks) == 4'h0)
		else $error("page lock cleared");
	side_mirror_a: assert property (fourLaneEnable == statusWord[9] && securityPageLocks == statusWord[13:10])
		else $error("side outputs differ from status");
	suspend_state_a: assert property (suspendReq |-> statusWord[15] && !statusWord[0] && $past(statusWord[0]))
		else $error("suspend state wrong");
	resume_state_a: assert property (resumeReq |-> !statusWord[15] && statusWord[0] && $past(statusWord[15]))
		else $error("resume state wrong");
	read_release_a: assert property ($rose(csN) |-> ##[1:6] !dataOutEn)
		else $error("output kept after deselect");
endmodule
bind fsap_status_core fsap_checker chk_u (.core_clk(core_clk), .rst_n(rst_n), .csN(csN),
	.writeGuardN(writeGuardN), .dataOutEn(dataOutEn), .engineDone(engineDone),
	.opStart(opStart), .suspendReq(suspendReq), .resumeReq(resumeReq),
	.statusWord(statusWord), .fourLaneEnable(fourLaneEnable),
	.securityPageLocks(securityPageLocks));
`default_nettype wire

// ===== bench/fsap_host.sv
// SPI host model driving the link pins in mode 0 with an 800 ns clock.
// Assumes a 100 ns core clock; every pin change follows a core clock edge.
`timescale 1ns/100ps
`default_nettype none
module fsap_host (
	// Pacing clock.
	input wire logic core_clk,
	// Link pins.
	output logic spiClk,
	output logic csN,
	output logic dataIn,
	input wire logic dataOut
);
	initial begin
		spiClk = 1'b0;
		csN = 1'b1;
		dataIn = 1'b0;
	end
	task automatic hp(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// Sends n bytes from the top of b, then clocks rdBits more bits in.
	// Each read bit is taken just before the fall that replaces it.
	task automatic frame(input logic [39:0] b, input int n, input int rdBits,
		output logic [7:0] rd);
		rd = 8'h00;
		csN <= 1'b0;
		for (int i = 0; i < n * 8 + rdBits; i++) begin
			if (i < n * 8)
				dataIn <= b[39 - i];
			hp(4);
			spiClk <= 1'b1;
			hp(3);
			if (i >= n * 8)
				rd = {rd[6:0], dataOut};
			hp(1);
			spiClk <= 1'b0;
		end
		hp(4);
		csN <= 1'b1;
		// A deselected device must not see a stable data level.
		dataIn <= ~dataIn;
		hp(8);
	endtask
endmodule
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the flash status and protection block.
// Assumes the host model paces the link and the bench plays the engine.
`timescale 1ns/100ps
`default_nettype none
`include "fsap_defines.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
	$display("BAD %0t got %h expected %h", $time, g, e); end end
module tb;
	typedef struct packed {logic [7:0] lo; logic [7:0] hi; logic [23:0] addr; logic hit;} fsap_row_t;
	logic core_clk = 1'b0, rst_n = 1'b0, writeGuardN = 1'b1, engineDone = 1'b0;
	wire spiClk, csN, dataIn, dataOut, dataOutEn, opStart, suspendReq, resumeReq, fourLaneEnable;
	wire [2:0] opKind;
	wire [23:0] opAddr;
	wire [15:0] statusWord;
	wire [3:0] securityPageLocks;
	int failures = 0, comparisons = 0, cyc = 0, nOps = 0, nSus = 0, nRes = 0;
	logic [7:0] rd;
	fsap_row_t rows [15] = '{
		'{8'h04, 8'h00, 24'h030000, 1'b1}, '{8'h04, 8'h00, 24'h02F000, 1'b0},
		'{8'h08, 8'h00, 24'h020000, 1'b1}, '{8'h24, 8'h00, 24'h00F000, 1'b1},
		'{8'h24, 8'h00, 24'h010000, 1'b0}, '{8'h0C, 8'h00, 24'h000000, 1'b1},
		'{8'h44, 8'h00, 24'h03F000, 1'b1}, '{8'h44, 8'h00, 24'h03E000, 1'b0},
		'{8'h54, 8'h00, 24'h038000, 1'b1}, '{8'h6C, 8'h00, 24'h003000, 1'b1},
		'{8'h6C, 8'h00, 24'h004000, 1'b0}, '{8'h7C, 8'h00, 24'h020000, 1'b1},
		'{8'h40, 8'h00, 24'h03F000, 1'b0}, '{8'h44, 8'h40, 24'h000000, 1'b1},
		'{8'h44, 8'h40, 24'h03F000, 1'b0}};
	fsap_status_core dut_u (.core_clk(core_clk), .rst_n(rst_n), .spiClk(spiClk), .csN(csN),
		.dataIn(dataIn), .writeGuardN(writeGuardN), .dataOut(dataOut), .dataOutEn(dataOutEn),
		.engineDone(engineDone), .opStart(opStart), .opKind(opKind), .opAddr(opAddr),
		.suspendReq(suspendReq), .resumeReq(resumeReq), .statusWord(statusWord),
		.fourLaneEnable(fourLaneEnable), .securityPageLocks(securityPageLocks));
	fsap_host host_u (.core_clk(core_clk), .spiClk(spiClk), .csN(csN), .dataIn(dataIn),
		.dataOut(dataOut));
	always #50 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc++;
		if (opStart === 1'b1)
			nOps++;
		if (suspendReq === 1'b1)
			nSus++;
		if (resumeReq === 1'b1)
			nRes++;
		if (cyc == 60000) begin
			failures++;
			wrap_up;
		end
	end
	task automatic wrap_up;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic op1(input logic [7:0] op);
		host_u.frame({op, 32'h0}, 1, 0, rd);
	endtask
	task automatic eng;
		engineDone <= 1'b1;
		@(posedge core_clk);
		engineDone <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask
	// Status write leaves time for the fixed busy period to end.
	task automatic wr(input logic [7:0] lo, input logic [7:0] hi, input logic we);
		if (we)
			op1(`FSAP_OP_WREN);
		host_u.frame({`FSAP_OP_WRSR, lo, hi, 16'h0}, 3, 0, rd);
		repeat (24) @(posedge core_clk);
	endtask
	task automatic rdst(input logic [7:0] op, input logic [7:0] exp);
		host_u.frame({op, 32'h0}, 1, 8, rd);
		`CHK(rd, exp)
	endtask
	task automatic erase(input logic [7:0] op, input logic [23:0] a, input logic go,
		input logic [2:0] kind);
		int n0;
		op1(`FSAP_OP_WREN);
		n0 = nOps;
		// Five bytes carry one data byte, so page programs are long enough too.
		host_u.frame({op, a, 8'h00}, 5, 0, rd);
		`CHK(nOps != n0, go)
		if (go) begin
			`CHK({opKind, opAddr}, {kind, a})
			eng;
			`CHK(statusWord[1:0], 2'b00)
		end
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		`CHK(statusWord, 16'h0000)
		foreach (rows[k]) begin
			wr(rows[k].lo, rows[k].hi, 1'b1);
			`CHK(statusWord, {rows[k].hi, rows[k].lo})
			erase(`FSAP_OP_SECTOR_ERASE, rows[k].addr, !rows[k].hit, `FSAP_KIND_SECTOR);
			$display("row %0d done", k);
		end
		wr(8'h44, 8'h00, 1'b1);
		erase(`FSAP_OP_BLOCK_ERASE, 24'h030000, 1'b0, `FSAP_KIND_BLOCK);
		erase(`FSAP_OP_BLOCK_ERASE, 24'h020000, 1'b1, `FSAP_KIND_BLOCK);
		erase(`FSAP_OP_CHIP_ERASE, 24'h000000, 1'b0, `FSAP_KIND_CHIP);
		erase(`FSAP_OP_PAGE_PROG, 24'h03E000, 1'b1, `FSAP_KIND_PAGE);
		erase(`FSAP_OP_QUAD_PROG, 24'h03F000, 1'b0, `FSAP_KIND_QPAGE);
		erase(`FSAP_OP_SEC_PROG, 24'h002000, 1'b1, `FSAP_KIND_SEC_PROG);
		wr(8'h00, 8'h00, 1'b1);
		erase(`FSAP_OP_CHIP_ERASE, 24'h000000, 1'b1, `FSAP_KIND_CHIP);
		$display("region test done");
		op1(`FSAP_OP_WREN);
		host_u.frame({`FSAP_OP_SECTOR_ERASE, 24'h010000, 8'h00}, 4, 0, rd);
		rdst(`FSAP_OP_RDSR_LOW, 8'h03);
		op1(`FSAP_OP_WRDI);
		`CHK(statusWord[1], 1'b1)
		op1(`FSAP_OP_SUSPEND);
		`CHK({statusWord[15], statusWord[0], nSus}, {2'b10, 32'd1})
		op1(`FSAP_OP_RESUME);
		`CHK({statusWord[15], statusWord[0], nRes}, {2'b01, 32'd1})
		eng;
		`CHK(statusWord, 16'h0000)
		$display("suspend test done");
		writeGuardN <= 1'b0;
		wr(8'h80, 8'h00, 1'b1);
		`CHK(statusWord, 16'h0080)
		wr(8'h84, 8'h00, 1'b1);
		`CHK(statusWord[15:2], 14'h0020)
		writeGuardN <= 1'b1;
		wr(8'h80, 8'h02, 1'b1);
		`CHK(statusWord, 16'h0280)
		writeGuardN <= 1'b0;
		wr(8'h84, 8'h02, 1'b1);
		`CHK({fourLaneEnable, statusWord}, 17'h10284)
		rdst(`FSAP_OP_RDSR_HIGH, 8'h02);
		wr(8'h00, 8'h00, 1'b0);
		`CHK(statusWord[15:2], 14'h00A1)
		$display("guard test done");
		wr(8'h00, 8'h04, 1'b1);
		`CHK(securityPageLocks, 4'h1)
		wr(8'h00, 8'h01, 1'b1);
		`CHK(statusWord, 16'h0500)
		wr(8'h00, 8'h00, 1'b1);
		`CHK(statusWord[15:2], 14'h0140)
		erase(`FSAP_OP_SEC_ERASE, 24'h000000, 1'b0, `FSAP_KIND_SEC_ERASE);
		erase(`FSAP_OP_SEC_ERASE, 24'h001000, 1'b1, `FSAP_KIND_SEC_ERASE);
		$display("lock test done");
		rst_n <= 1'b0;
		repeat (16) @(posedge core_clk);
		`CHK(statusWord, 16'h0000)
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		wr(8'h04, 8'h00, 1'b1);
		`CHK(statusWord, 16'h0004)
		$display("reset test done");
		wrap_up;
	end
endmodule
`default_nettype wire
